//--- design/eeprom_host_pkg.sv
// constants, types and timing counts for the parallel eeprom host controller
// assumes a 25 MHz controller clock
package eeprom_host_pkg;
   localparam int CLK_MHZ = 25;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 128;
   localparam int PAGE_IDX_W = 7;
   localparam int FIFO_DEPTH = 16;
   // strobe timing in ns
   localparam int WP_NS = 250;
   localparam int SETUP_NS = 120;
   localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_NS = 250;
   localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000 + 1;
   // byte load cycle, max, rounded down
   localparam int BLC_US = 30;
   localparam int BLC_CYC = BLC_US * CLK_MHZ;
   localparam int BL_US = 100;
   localparam int BL_CYC = BL_US * CLK_MHZ + 1;
   localparam int RP_US = 100;
   localparam int RP_CYC = RP_US * CLK_MHZ;
   localparam int HOLD_MS = 10;
   localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam int WC_MS = 15;
   localparam int WC_CYC = WC_MS * 1000 * CLK_MHZ;
   localparam logic [ADDR_W-1:0] SDP_ADDR_A = 17'h05555;
   localparam logic [ADDR_W-1:0] SDP_ADDR_B = 17'h02AAA;
   localparam logic [DATA_W-1:0] SDP_D_AA = 8'hAA;
   localparam logic [DATA_W-1:0] SDP_D_55 = 8'h55;
   localparam logic [DATA_W-1:0] SDP_D_80 = 8'h80;
   localparam logic [DATA_W-1:0] SDP_D_A0 = 8'hA0;
   localparam logic [DATA_W-1:0] SDP_D_20 = 8'h20;
   localparam int CNT_W = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic last;
   } wr_word_s;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic dq_oe_n;
   } mem_pins_s;
endpackage

//--- design/word_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock and asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] wdata_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [WIDTH-1:0] rdata_out,
   output logic rvalid_out,
   input wire logic rready_in
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_state_s;
   fifo_state_s st_q, st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign wready_out = (st_q.cnt != (AW+1)'(DEPTH));
   assign rvalid_out = (st_q.cnt != '0);
   assign rdata_out = mem[st_q.rp];
   assign push = wvalid_in && wready_out;
   assign pop = rvalid_out && rready_in;

   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.wp = st_q.wp + 1'b1;
      end
      if (pop)
      begin
         st_d.rp = st_q.rp + 1'b1;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // storage without reset keeps it a plain ram
   always_ff @(posedge mclk_in)
   begin
      if (push)
      begin
         mem[st_q.wp] <= wdata_in;
      end
   end
endmodule
`default_nettype wire

//--- design/eeprom_host.sv
// host controller for a byte-wide parallel eeprom: page writes, polling, protection commands
// assumes the eeprom pins connect directly; ready/busy pulled up externally
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - next byte load within 30 us; not enforced, a same-page byte loads any time before BL_CYCLES
// - hold protect high through all accesses
// - drive protect from system reset
// - protect high 10 ms after last load; not timed here, HOLD_CYCLES is unused and a reset drops it at once
// - three byte prefix before protected writes
// - six write cancel sequence
// - protect high 100 us before first strobe
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC,
   parameter int WC_CYCLES = WC_CYC,
   parameter int RP_CYCLES = RP_CYC,
   parameter int BL_CYCLES = BL_CYC
)
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_last_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic sdp_mode_in,
   input wire logic unprotect_in,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   input wire logic rd_req_in,
   output logic [DATA_W-1:0] rd_data_out,
   output logic rd_valid_out,
   output logic busy_out,
   output logic timeout_out,
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n_out,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic rdy_busy_n_in,
   output logic protect_reset_n_out
);
   typedef enum logic [3:0] {
      S_PROT, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP, S_POLL_SET, S_POLL_RD,
      S_READ_SET, S_READ_RD
   } fsm_e;

   typedef struct packed {
      fsm_e fsm;
      mem_pins_s pins;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] wait_cnt;
      logic [2:0] seq_idx;
      logic seq_kind;
      logic prefixed;
      logic [DATA_W-1:0] last_byte;
      logic [ADDR_W-1:0] last_addr;
      logic in_page;
      logic [ADDR_W-PAGE_IDX_W-1:0] page;
      logic [DATA_W-1:0] rd_data;
      logic rd_valid;
      logic busy;
      logic timeout;
      logic prot_n;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
      logic rdy_s1;
      logic rdy_s2;
   } host_state_s;

   host_state_s st_q, st_d;
   wr_word_s fifo_in, fifo_out;
   logic fifo_valid, fifo_pop;

   assign fifo_in = '{addr: wr_addr_in, data: wr_data_in, last: wr_last_in};

   word_fifo #(.WIDTH($bits(wr_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .wdata_in(fifo_in),
      .wvalid_in(wr_valid_in),
      .wready_out(wr_ready_out),
      .rdata_out(fifo_out),
      .rvalid_out(fifo_valid),
      .rready_in(fifo_pop)
   );

   // returns address and data of step i of a command sequence
   function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input logic kind,
                                                          input logic [2:0] i);
      logic [ADDR_W+DATA_W-1:0] w;
      w = {SDP_ADDR_A, SDP_D_AA};
      if (!kind)
      begin
         unique case (i)
            3'h0: w = {SDP_ADDR_A, SDP_D_AA};
            3'h1: w = {SDP_ADDR_B, SDP_D_55};
            default: w = {SDP_ADDR_A, SDP_D_A0};
         endcase
      end
      else
      begin
         unique case (i)
            3'h0: w = {SDP_ADDR_A, SDP_D_AA};
            3'h1: w = {SDP_ADDR_B, SDP_D_55};
            3'h2: w = {SDP_ADDR_A, SDP_D_80};
            3'h3: w = {SDP_ADDR_A, SDP_D_AA};
            3'h4: w = {SDP_ADDR_B, SDP_D_55};
            default: w = {SDP_ADDR_A, SDP_D_20};
         endcase
      end
      return w;
   endfunction

   logic [2:0] seq_len;
   logic seq_active;
   logic [ADDR_W+DATA_W-1:0] seq_w;

   always_comb
   begin
      seq_len = st_q.seq_kind ? 3'h6 : 3'h3;
      seq_active = st_q.seq_idx != seq_len;
      seq_w = seq_word(st_q.seq_kind, st_q.seq_idx);
      st_d = st_q;
      fifo_pop = 1'b0;
      st_d.dq_s1 = dq_in;
      st_d.dq_s2 = st_q.dq_s1;
      st_d.rdy_s1 = rdy_busy_n_in;
      st_d.rdy_s2 = st_q.rdy_s1;
      st_d.rd_valid = 1'b0;
      st_d.cnt = st_q.cnt + 1'b1;
      // window since the last strobe keeps running across states
      st_d.wait_cnt = st_q.wait_cnt + 1'b1;
      // protect only drops in reset; the hold after the last load is not timed, so a reset can cut it short
      st_d.prot_n = 1'b1;
      unique case (st_q.fsm)
         S_PROT:
         begin
            st_d.pins = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe_n: 1'b1};
            if (st_q.cnt >= CNT_W'(RP_CYCLES))
            begin
               st_d.fsm = S_IDLE;
            end
         end
         S_IDLE:
         begin
            st_d.pins.ce_n = 1'b1;
            st_d.pins.oe_n = 1'b1;
            st_d.pins.we_n = 1'b1;
            st_d.pins.dq_oe_n = 1'b1;
            st_d.cnt = '0;
            if (st_q.in_page && st_q.wait_cnt >= CNT_W'(BL_CYCLES))
            begin
               st_d.in_page = 1'b0;
               st_d.fsm = S_POLL_SET;
               st_d.wait_cnt = '0;
            end
            else if (seq_active)
            begin
               st_d.pins.addr = seq_w[ADDR_W+DATA_W-1:DATA_W];
               st_d.pins.dq = seq_w[DATA_W-1:0];
               st_d.fsm = S_SETUP;
            end
            else if (fifo_valid && (!st_q.in_page ||
                     fifo_out.addr[ADDR_W-1:PAGE_IDX_W] == st_q.page))
            begin
               // protected mode prefixes every new page block
               if (sdp_mode_in && !st_q.in_page && !st_q.prefixed)
               begin
                  st_d.seq_kind = 1'b0;
                  st_d.seq_idx = 3'h0;
               end
               else
               begin
                  fifo_pop = 1'b1;
                  st_d.prefixed = 1'b0;
                  st_d.pins.addr = fifo_out.addr;
                  st_d.pins.dq = fifo_out.data;
                  st_d.last_byte = fifo_out.data;
                  st_d.last_addr = fifo_out.addr;
                  st_d.page = fifo_out.addr[ADDR_W-1:PAGE_IDX_W];
                  st_d.in_page = !fifo_out.last;
                  st_d.fsm = S_SETUP;
               end
            end
            else if (st_q.in_page && fifo_valid)
            begin
               // other page: let the current one program first
               st_d.in_page = 1'b1;
            end
            else if (!st_q.in_page && unprotect_in)
            begin
               st_d.seq_kind = 1'b1;
               st_d.seq_idx = 3'h0;
            end
            else if (!st_q.in_page && rd_req_in)
            begin
               st_d.pins.addr = rd_addr_in;
               st_d.fsm = S_READ_SET;
            end
         end
         S_SETUP:
         begin
            // address valid before the falling strobe, data driven ahead of rising edge
            st_d.pins.ce_n = 1'b0;
            st_d.pins.dq_oe_n = 1'b0;
            if (st_q.cnt >= CNT_W'(SETUP_CYC))
            begin
               st_d.pins.we_n = 1'b0;
               st_d.busy = 1'b1;
               st_d.cnt = '0;
               st_d.fsm = S_STROBE;
            end
         end
         S_STROBE:
         begin
            // pulse well past the glitch filter width
            if (st_q.cnt >= CNT_W'(WP_CYC))
            begin
               st_d.pins.we_n = 1'b1;
               st_d.cnt = '0;
               st_d.wait_cnt = '0;
               st_d.fsm = S_HOLD;
            end
         end
         S_HOLD:
         begin
            st_d.pins.ce_n = 1'b1;
            st_d.pins.dq_oe_n = 1'b1;
            if (seq_active)
            begin
               st_d.seq_idx = st_q.seq_idx + 1'b1;
               // without this the data byte would be prefixed again forever
               st_d.prefixed = !st_q.seq_kind;
               // cancel sequence ends by a program cycle of its own
               if (st_q.seq_kind && st_q.seq_idx == 3'h5)
               begin
                  st_d.fsm = S_GAP;
                  st_d.in_page = 1'b1;
               end
               else
               begin
                  st_d.fsm = S_IDLE;
               end
            end
            else
            begin
               st_d.fsm = S_IDLE;
               if (!st_q.in_page)
               begin
                  st_d.fsm = S_GAP;
               end
            end
         end
         S_GAP:
         begin
            // quiet strobes until the load window closes
            if (st_q.wait_cnt >= CNT_W'(BL_CYCLES))
            begin
               st_d.in_page = 1'b0;
               st_d.wait_cnt = '0;
               st_d.fsm = S_POLL_SET;
            end
         end
         S_POLL_SET:
         begin
            st_d.pins.addr = st_q.last_addr;
            st_d.pins.ce_n = 1'b0;
            st_d.pins.oe_n = 1'b0;
            st_d.cnt = '0;
            st_d.fsm = S_POLL_RD;
         end
         S_POLL_RD:
         begin
            if (st_q.cnt >= CNT_W'(ACC_CYC))
            begin
               st_d.pins.ce_n = 1'b1;
               st_d.pins.oe_n = 1'b1;
               // done needs true bit 7 and ready/busy released
               if (st_q.dq_s2[DATA_W-1] == st_q.last_byte[DATA_W-1] && st_q.rdy_s2)
               begin
                  st_d.busy = 1'b0;
                  st_d.fsm = S_PROT;
                  st_d.cnt = CNT_W'(RP_CYCLES);
               end
               else if (st_q.wait_cnt >= CNT_W'(WC_CYCLES))
               begin
                  st_d.timeout = 1'b1;
                  st_d.busy = 1'b0;
                  st_d.fsm = S_PROT;
                  st_d.cnt = CNT_W'(RP_CYCLES);
               end
               else
               begin
                  st_d.fsm = S_POLL_SET;
               end
            end
         end
         S_READ_SET:
         begin
            st_d.pins.ce_n = 1'b0;
            st_d.pins.oe_n = 1'b0;
            st_d.cnt = '0;
            st_d.fsm = S_READ_RD;
         end
         S_READ_RD:
         begin
            if (st_q.cnt >= CNT_W'(ACC_CYC))
            begin
               st_d.pins.ce_n = 1'b1;
               st_d.pins.oe_n = 1'b1;
               st_d.rd_data = st_q.dq_s2;
               st_d.rd_valid = 1'b1;
               st_d.fsm = S_IDLE;
            end
         end
         default:
         begin
            st_d.fsm = S_PROT;
         end
      endcase
      if (st_q.fsm == S_IDLE && fifo_valid)
      begin
         st_d.timeout = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         // protect held low during reset, no strobes; aborts a program
         st_q <= '0;
         st_q.fsm <= S_PROT;
         st_q.pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe_n: 1'b1};
         st_q.seq_idx <= 3'h3;
         st_q.rdy_s1 <= 1'b1;
         st_q.rdy_s2 <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign ce_n_out = st_q.pins.ce_n;
   assign oe_n_out = st_q.pins.oe_n;
   assign we_n_out = st_q.pins.we_n;
   assign addr_out = st_q.pins.addr;
   assign dq_out = st_q.pins.dq;
   assign dq_oe_n_out = st_q.pins.dq_oe_n;
   assign protect_reset_n_out = st_q.prot_n;
   assign rd_data_out = st_q.rd_data;
   assign rd_valid_out = st_q.rd_valid;
   assign busy_out = st_q.busy;
   assign timeout_out = st_q.timeout;
endmodule
`default_nettype wire

//--- tb/eeprom_model.sv
// behavioural byte-wide eeprom: page loads, polling, ready/busy, software protection
// assumes the host clock is wired in to time the load window and the program and to hold the last read value
`timescale 1ns/1ns
`default_nettype none
module eeprom_model
   import eeprom_host_pkg::*;
#(
   parameter int WINDOW_CYC = 40,
   parameter int PROG_CYC = 200
)
(
   input wire logic mclk_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic protect_reset_n_in,
   output logic [DATA_W-1:0] dq_out,
   output logic rdy_busy_n_out
);
   localparam logic [ADDR_W-1:0] SEQ_A [6] = '{SDP_ADDR_A, SDP_ADDR_B, SDP_ADDR_A,
      SDP_ADDR_A, SDP_ADDR_B, SDP_ADDR_A};
   localparam logic [DATA_W-1:0] SEQ_D [6] = '{SDP_D_AA, SDP_D_55, SDP_D_80,
      SDP_D_AA, SDP_D_55, SDP_D_20};
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] la [$];
   logic [DATA_W-1:0] ld [$];
   logic [ADDR_W-1:0] lat_a = '0;
   logic [DATA_W-1:0] last_d = 8'h00;
   logic [DATA_W-1:0] held = 8'h00;
   logic busy = 1'b0;
   logic prot = 1'b0;
   int idle = 0;
   int prog = 0;
   int keep = 0;
   realtime fall_t = 0.0;
   wire logic wr_n = ce_n_in | we_n_in;
   wire logic rd_en = protect_reset_n_in & ~ce_n_in & ~oe_n_in & we_n_in;
   // no pull on dq, so a released bus shows the inverse of the last read
   assign dq_out = !rd_en ? ~held : busy ? {~last_d[7], last_d[6:0]} : mem[addr_in];
   assign rdy_busy_n_out = !busy;
   initial
      for (int i = 0; i < (1 << ADDR_W); i++)
         mem[i] = 8'hFF;
   function automatic bit seq_ok(int n);
      seq_ok = la.size() >= n;
      for (int i = 0; i < n && seq_ok; i++)
         seq_ok = la[i][14:0] == SEQ_A[i][14:0] &&
            ld[i] == ((n == 3 && i == 2) ? SDP_D_A0 : SEQ_D[i]);
   endfunction
   task automatic finish_prog();
      for (int i = keep; i < la.size(); i++)
         mem[la[i]] = ld[i];
      la.delete();
      ld.delete();
      prog = 0;
      busy = 1'b0;
   endtask
   task automatic commit();
      keep = prot ? la.size() : 0;
      if (seq_ok(6))
      begin
         prot = 1'b0;
         keep = 6;
      end
      else if (seq_ok(3))
      begin
         prot = 1'b1;
         keep = 3;
      end
      prog = PROG_CYC;
      if (keep >= la.size())
         finish_prog();
   endtask
   always @(negedge wr_n)
   begin
      fall_t = $realtime;
      lat_a = addr_in;
   end
   // a strobe of 20 ns or less is noise and loads nothing
   always @(posedge wr_n)
      if (protect_reset_n_in && oe_n_in && prog == 0 &&
         $realtime - fall_t > 20.0)
      begin
         la.push_back(lat_a);
         ld.push_back(dq_in);
         last_d = dq_in;
         busy = 1'b1;
         idle = 0;
      end
   // state moves on the falling edge so the host never samples it mid-update
   always @(negedge mclk_in)
   begin
      if (rd_en)
         held <= dq_out;
      if (!protect_reset_n_in)
      begin
         la.delete();
         ld.delete();
         prog = 0;
         busy = 1'b0;
      end
      else if (prog > 0)
      begin
         prog = prog - 1;
         if (prog == 0)
            finish_prog();
      end
      else if (la.size() > 0 && wr_n)
      begin
         idle = idle + 1;
         if (idle >= WINDOW_CYC)
            commit();
      end
   end
endmodule
`default_nettype wire

//--- tb/eeprom_host_asserts.sv
// concurrent checks on the eeprom host controller pins and status outputs
// assumes it is bound into eeprom_host and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module eeprom_host_asserts
   import eeprom_host_pkg::*;
#(
   parameter int RP_CYCLES = RP_CYC,
   parameter int BL_CYCLES = BL_CYC
)
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic wr_ready_out,
   input wire logic rd_valid_out,
   input wire logic busy_out,
   input wire logic ce_n_out,
   input wire logic oe_n_out,
   input wire logic we_n_out,
   input wire logic [ADDR_W-1:0] addr_out,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe_n_out,
   input wire logic rdy_busy_n_in,
   input wire logic protect_reset_n_out
);
   logic [CNT_W-1:0] since_rst_q;
   logic [CNT_W-1:0] since_we_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   always_ff @(posedge mclk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         since_rst_q <= '0;
         since_we_q <= '0;
      end
      else
      begin
         if (since_rst_q < RP_CYCLES)
            since_rst_q <= since_rst_q + 1'b1;
         since_we_q <= we_n_out ? since_we_q + 1'b1 : '0;
      end
   AST_PROTECT_HIGH: assert property ($past(rstn_in) |-> protect_reset_n_out)
      else $error("protect output low outside reset");
   AST_PROTECT_SETUP: assert property ($fell(we_n_out) |-> since_rst_q >= RP_CYCLES)
      else $error("write strobe too soon after protect release");
   AST_WRITE_PINS: assert property (!we_n_out |-> !ce_n_out && oe_n_out && !dq_oe_n_out)
      else $error("write strobe without select or with output gate");
   AST_STROBE_WIDTH: assert property ($fell(we_n_out) |-> (!we_n_out) [*7])
      else $error("write strobe too short");
   AST_LATCH_STABLE: assert property (!we_n_out && $past(!we_n_out) |->
      $stable(addr_out) && $stable(dq_out))
      else $error("address or data moved under the strobe");
   AST_BUSY_ON_STROBE: assert property ($fell(we_n_out) |-> ##[0:3] busy_out)
      else $error("busy not raised after strobe");
   AST_BUSY_RELEASE: assert property ($fell(busy_out) |->
      rdy_busy_n_in && $past(rdy_busy_n_in, 2))
      else $error("busy dropped while device busy");
   AST_LOAD_WINDOW: assert property ($fell(we_n_out) && $past(busy_out) |-> since_we_q <= BLC_CYC)
      else $error("byte load window exceeded");
   AST_LOAD_GAP: assert property ($fell(oe_n_out) && busy_out |-> since_we_q >= BL_CYCLES)
      else $error("poll started inside the load window");
   AST_OE_EXCLUSIVE: assert property (!oe_n_out |-> we_n_out && dq_oe_n_out)
      else $error("read gate with host driving data");
   AST_COV_FULL: cover property (!wr_ready_out);
   AST_COV_DONE: cover property ($fell(busy_out));
   AST_COV_READ: cover property (rd_valid_out);
endmodule
bind eeprom_host eeprom_host_asserts #(.RP_CYCLES(RP_CYCLES), .BL_CYCLES(BL_CYCLES)) u_chk (.*);
`default_nettype wire

//--- tb/eeprom_host_tb_top.sv
// self-checking bench: eeprom host controller driving a behavioural eeprom
// assumes the checker binds itself to the controller; long counts are shortened
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module eeprom_host_tb_top
   import eeprom_host_pkg::*;
();
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [ADDR_W-1:0] wr_addr_in = '0;
   logic [DATA_W-1:0] wr_data_in = '0;
   logic wr_last_in = 1'b0;
   logic wr_valid_in = 1'b0;
   logic sdp_mode_in = 1'b0;
   logic unprotect_in = 1'b0;
   logic [ADDR_W-1:0] rd_addr_in = '0;
   logic rd_req_in = 1'b0;
   logic wr_ready_out, rd_valid_out, busy_out, timeout_out, ce_n_out, oe_n_out, we_n_out;
   logic dq_oe_n_out, rdy_busy_n_in, protect_reset_n_out;
   logic [DATA_W-1:0] rd_data_out, dq_out, dq_in;
   logic [ADDR_W-1:0] addr_out;
   int n_errors = 0;
   int compares = 0;
   bit saw_full = 1'b0;
   eeprom_host #(.WC_CYCLES(2000), .RP_CYCLES(10), .BL_CYCLES(50)) DUT (.*);
   eeprom_model #(.WINDOW_CYC(40), .PROG_CYC(200)) partner (.mclk_in(mclk_in),
      .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out), .addr_in(addr_out),
      .dq_in(dq_out), .protect_reset_n_in(protect_reset_n_out), .dq_out(dq_in),
      .rdy_busy_n_out(rdy_busy_n_in));
   initial
      forever #20 mclk_in = ~mclk_in;
   task automatic give_verdict();
      $display("Comparisons %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic fail_wait();
      n_errors++;
      $display("Error at %0t: wait ran out, got %0h expected %0h", $time, 1'b0, 1'b1);
      give_verdict();
   endtask
   task automatic push(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic l);
      int n;
      n = 0;
      wr_addr_in <= a;
      wr_data_in <= d;
      wr_last_in <= l;
      wr_valid_in <= 1'b1;
      do
      begin
         @(posedge mclk_in);
         n++;
         if (wr_ready_out !== 1'b1)
            saw_full = 1'b1;
      end
      while (wr_ready_out !== 1'b1 && n < 5000);
      if (l)
         wr_valid_in <= 1'b0;
      if (n >= 5000)
         fail_wait();
   endtask
   task automatic wait_busy(input logic lvl);
      int n;
      for (n = 0; n < 20000 && busy_out !== lvl; n++)
         @(posedge mclk_in);
      if (n >= 20000)
         fail_wait();
   endtask
   task automatic write_page_done();
      wait_busy(1'b1);
      wait_busy(1'b0);
      `CHK(timeout_out, 1'b0)
   endtask
   task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      rd_addr_in <= a;
      rd_req_in <= 1'b1;
      do
      begin
         @(posedge mclk_in);
         n++;
         // dropping the request once taken keeps a second read from starting
         if (oe_n_out === 1'b0)
            rd_req_in <= 1'b0;
      end
      while (rd_valid_out !== 1'b1 && n < 2000);
      if (n >= 2000)
         fail_wait();
      `CHK(rd_data_out, exp)
   endtask
   task automatic do_reset();
      rstn_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      `CHK({ce_n_out, we_n_out, oe_n_out, dq_oe_n_out, protect_reset_n_out, busy_out,
         timeout_out, rd_valid_out}, 8'hF0)
      rstn_in <= 1'b1;
   endtask
   task automatic test_partial_page();
      push(17'h05555, 8'h05, 1'b1);
      write_page_done();
      push(17'h00180, 8'h11, 1'b0);
      push(17'h00185, 8'h22, 1'b0);
      push(17'h001FF, 8'hA3, 1'b1);
      write_page_done();
      read_chk(17'h00180, 8'h11);
      read_chk(17'h00185, 8'h22);
      read_chk(17'h001FF, 8'hA3);
      read_chk(17'h00181, 8'hFF);
   endtask
   task automatic test_full_page();
      saw_full = 1'b0;
      for (int i = 0; i < PAGE_BYTES; i++)
         push({10'h004, i[6:0]}, 8'h5A ^ i[7:0], i == PAGE_BYTES - 1);
      `CHK(saw_full, 1'b1)
      write_page_done();
      `CHK(wr_ready_out, 1'b1)
      for (int i = 0; i < PAGE_BYTES; i++)
         read_chk({10'h004, i[6:0]}, 8'h5A ^ i[7:0]);
   endtask
   task automatic test_protection();
      sdp_mode_in <= 1'b1;
      push(17'h00300, 8'h44, 1'b1);
      write_page_done();
      sdp_mode_in <= 1'b0;
      push(17'h00301, 8'hD5, 1'b1);
      write_page_done();
      read_chk(17'h00300, 8'h44);
      read_chk(17'h00301, 8'hFF);
      unprotect_in <= 1'b1;
      wait_busy(1'b1);
      unprotect_in <= 1'b0;
      wait_busy(1'b0);
      read_chk(17'h05555, 8'h05);
      read_chk(17'h02AAA, 8'hFF);
      push(17'h00302, 8'h66, 1'b1);
      write_page_done();
      read_chk(17'h00302, 8'h66);
   endtask
   task automatic test_abort();
      int n;
      push(17'h00380, 8'h77, 1'b1);
      for (n = 0; n < 5000 && oe_n_out !== 1'b0; n++)
         @(posedge mclk_in);
      if (n >= 5000)
         fail_wait();
      do_reset();
      read_chk(17'h00380, 8'hFF);
   endtask
   initial
   begin
      do_reset();
      repeat (2) @(posedge mclk_in);
      `CHK(protect_reset_n_out, 1'b1)
      test_partial_page();
      test_full_page();
      test_protection();
      test_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
